/* rtl/interrupt_enable_flag_logic.sv */
// module: interrupt enable and flag registers with an axi4-lite slave
`default_nettype none
module interrupt_enable_flag_logic
	import irq_ctrl_pkg::*;
#(
	parameter bit EXTENDED = 1'b1 // 1 selects the larger enable layout
) (
	input  wire logic        core_clk,         // system clock
	input  wire logic        srst,             // synchronous reset
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// core interrupt sources: timer0 and external one-cycle pulses, port b pin levels
	input  wire logic        timer0Overflow,
	input  wire logic        externalInterruptPin,
	input  wire logic [3:0]  upperPortBPins,
	// peripheral requests, levels held by the peripheral
	input  wire logic [7:0]  peripheralRequest,
	// request to the core
	output logic             irqRequest
);
	// ==========================================================
	// write channel capture
	logic        awHeld;  // write address taken
	logic        wHeld;   // write data taken
	logic [9:0]  awAddr;  // held write address
	logic [7:0]  wData;   // held low byte
	logic        wLane0;  // low byte lane enabled
	logic        doWrite; // both halves present, commit this cycle

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

	// address and data may arrive in either order
	always_ff @(posedge core_clk) begin
		if (srst) begin
			awHeld <= 1'b0;
			awAddr <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr[ADDR_WIDTH-1:0];
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	// data half of the write
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wHeld  <= 1'b0;
			wData  <= 8'h00;
			wLane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld  <= 1'b1;
			wData  <= s_axi_wdata[7:0];
			wLane0 <= s_axi_wstrb[0];
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	// ==========================================================
	// address decode helper, used by both channels
	function automatic logic [1:0] decodeAddr(input logic [9:0] a);
		// 0 none, 1 control, 2 enable, 3 peripheral flags
		if (a == CTRL_ADDR) begin
			decodeAddr = 2'd1;
		end else if (a == PIE_ADDR) begin
			decodeAddr = 2'd2;
		end else if (a == PFLAG_ADDR) begin
			decodeAddr = 2'd3;
		end else begin
			decodeAddr = 2'd0;
		end
	endfunction

	logic        upperZero;  // upper address bits clear
	logic [31:0] awFull;     // kept for the unmapped check
	logic [1:0]  wSel;       // selected register on write
	logic        ctrlWrite;  // byte write to control
	logic        pieWrite;   // byte write to enables

	// full address above the map is unmapped
	always_ff @(posedge core_clk) begin
		if (srst) begin
			awFull <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awFull <= s_axi_awaddr;
		end
	end
	assign upperZero = (awFull[31:ADDR_WIDTH] == 22'h000000);
	assign wSel      = upperZero ? decodeAddr(awAddr) : 2'd0;
	assign ctrlWrite = doWrite && wLane0 && (wSel == 2'd1);
	assign pieWrite  = doWrite && wLane0 && (wSel == 2'd2);

	// response follows the commit by one cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wSel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// control register: enables stored here, flags in leaf cells
	logic [4:0] ctrlEnables; // global, group, timer0, external, port

	// the enables are plain read/write bits
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrlEnables <= CTRL_RESET[7:3];
		end else if (ctrlWrite) begin
			ctrlEnables <= wData[7:3];
		end
	end

	logic globalEnable; // every interrupt may pass
	logic groupEnable;  // peripheral group may pass
	assign globalEnable = ctrlEnables[GLOBAL_BIT-3];
	assign groupEnable  = ctrlEnables[PGROUP_BIT-3];

	// ==========================================================
	// core source flags
	logic portChange;  // pulse from the pin watcher
	logic [2:0] coreEvent; // timer0, external, port change
	logic [2:0] coreFlag;  // flag outputs, same order

	port_change_detect u_port_change (
		.core_clk       (core_clk),
		.srst           (srst),
		.upperPortBPins (upperPortBPins),
		.changeEvent    (portChange)
	);

	// events set flags whatever the enables say
	assign coreEvent = {timer0Overflow, externalInterruptPin, portChange};

	// flag bits 2..0 map onto coreFlag 2..0
	for (genvar i = 0; i < 3; i++) begin : g_flag
		irq_flag_bit u_flag (
			.core_clk   (core_clk),
			.srst       (srst),
			.setEvent   (coreEvent[i]),
			.clearWrite (ctrlWrite && !wData[i]),
			.setWrite   (ctrlWrite && wData[i]),
			.flag       (coreFlag[i])
		);
	end

	// ==========================================================
	// peripheral enable register at its own offset
	// the smaller layout holds the reserved bits writable but the
	// unimplemented bits 5..4 read zero; software keeps 7..6 clear
	localparam logic [7:0] PIE_MASK = EXTENDED ? PIE_MASK_EXTENDED
	                                           : PIE_MASK_BASIC;
	logic [7:0] pieEnable; // individual peripheral enables

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pieEnable <= PIE_RESET;
		end else if (pieWrite) begin
			pieEnable <= wData & PIE_MASK;
		end
	end

	// reserved bit never passes a request even if software sets it
	logic [7:0] pieLive; // enables that reach the gate
	always_comb begin
		pieLive          = pieEnable;
		pieLive[RSV_BIT] = 1'b0;
		if (!EXTENDED) begin
			pieLive[PSP_BIT] = 1'b0;
		end
	end

	// ==========================================================
	// request gating
	logic [7:0] periphHit; // enabled peripheral requests
	logic       periphAny; // any peripheral passes the group gate
	logic       coreAny;   // any core source enabled and flagged

	always_comb begin
		periphHit          = 8'h00;
		periphHit[TMR1_BIT] = peripheralRequest[TMR1_BIT] && pieLive[TMR1_BIT];
		periphHit[TMR2_BIT] = peripheralRequest[TMR2_BIT] && pieLive[TMR2_BIT];
		periphHit[CCP_BIT]  = peripheralRequest[CCP_BIT] && pieLive[CCP_BIT];
		periphHit[SSP_BIT]  = peripheralRequest[SSP_BIT] && pieLive[SSP_BIT];
		periphHit[UTX_BIT]  = peripheralRequest[UTX_BIT] && pieLive[UTX_BIT];
		periphHit[URX_BIT]  = peripheralRequest[URX_BIT] && pieLive[URX_BIT];
		periphHit[PSP_BIT]  = peripheralRequest[PSP_BIT] && pieLive[PSP_BIT];
	end

	assign periphAny = groupEnable && (periphHit != 8'h00);
	assign coreAny   = (coreFlag & ctrlEnables[2:0]) != 3'b000;

	// registered so the core sees a clean level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= globalEnable && (coreAny || periphAny);
		end
	end

	// ==========================================================
	// read channel
	logic [1:0] rSel;   // selected register on read
	logic [7:0] rByte;  // byte to return

	assign s_axi_arready = !s_axi_rvalid;
	assign rSel = (s_axi_araddr[31:ADDR_WIDTH] == 22'h000000)
	              ? decodeAddr(s_axi_araddr[ADDR_WIDTH-1:0]) : 2'd0;

	// read mux: control, enables, peripheral requests masked by PIE_MASK
	always_comb begin
		case (rSel)
			2'd1:    rByte = {ctrlEnables, coreFlag};
			2'd2:    rByte = pieEnable;
			2'd3:    rByte = peripheralRequest & PIE_MASK;
			default: rByte = 8'h00;
		endcase
	end

	// one read at a time; data held until rready
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rByte};
			s_axi_rresp  <= (rSel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* rtl/irq_ctrl_pkg.sv */
// package: register map, field positions and reset values of the interrupt block
`default_nettype none
package irq_ctrl_pkg;
	// ==========================================================
	// register byte addresses (printed offsets are not all word aligned,
	// so each printed offset is an index and the byte address is index*4)
	localparam logic [7:0]  CTRL_INDEX       = 8'h0b;
	localparam logic [7:0]  PIE_INDEX        = 8'h8c;
	localparam logic [7:0]  PFLAG_INDEX      = 8'h0c;
	localparam logic [9:0]  CTRL_ADDR        = {CTRL_INDEX, 2'b00};
	localparam logic [9:0]  PIE_ADDR         = {PIE_INDEX, 2'b00};
	localparam logic [9:0]  PFLAG_ADDR       = {PFLAG_INDEX, 2'b00};
	localparam int          ADDR_WIDTH       = 10;
	// ==========================================================
	// control register fields
	localparam int GLOBAL_BIT   = 7;
	localparam int PGROUP_BIT   = 6;
	localparam int T0_EN_BIT    = 5;
	localparam int EXT_EN_BIT   = 4;
	localparam int PCH_EN_BIT   = 3;
	localparam int T0_FLAG_BIT  = 2;
	localparam int EXT_FLAG_BIT = 1;
	localparam int PCH_FLAG_BIT = 0;
	// ==========================================================
	// peripheral enable fields
	localparam int TMR1_BIT = 0;
	localparam int TMR2_BIT = 1;
	localparam int CCP_BIT  = 2;
	localparam int SSP_BIT  = 3;
	localparam int UTX_BIT  = 4;
	localparam int URX_BIT  = 5;
	localparam int RSV_BIT  = 6;
	localparam int PSP_BIT  = 7;
	// writable masks of the two layouts
	localparam logic [7:0] PIE_MASK_BASIC    = 8'hcf;
	localparam logic [7:0] PIE_MASK_EXTENDED = 8'hff;
	// ==========================================================
	// reset values
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] PIE_RESET   = 8'h00;
	localparam logic [3:0] PORTB_RESET = 4'h0;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* rtl/irq_flag_bit.sv */
// module: one sticky flag where a hardware set beats a software clear
`default_nettype none
module irq_flag_bit (
	input  wire logic core_clk,   // system clock
	input  wire logic srst,       // synchronous reset
	input  wire logic setEvent,   // hardware event, one cycle
	input  wire logic clearWrite, // software writes zero
	input  wire logic setWrite,   // software writes one
	output logic      flag        // flag state
);
	// ==========================================================
	// flag storage
	// set is checked first so a simultaneous clear loses
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else if (setEvent || setWrite) begin
			flag <= 1'b1;
		end else if (clearWrite) begin
			flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* rtl/port_change_detect.sv */
// module: detects a change on the upper four port b pins
`default_nettype none
module port_change_detect
	import irq_ctrl_pkg::*;
(
	input  wire logic       core_clk,        // system clock
	input  wire logic       srst,            // synchronous reset
	input  wire logic [3:0] upperPortBPins,  // pin levels, synchronous
	output logic            changeEvent      // one-cycle pulse on change
);
	// ==========================================================
	// last seen levels
	logic [3:0] lastPins; // previous sample
	logic       primed;   // first sample after reset taken

	// reference is caught after reset release, never at reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lastPins <= PORTB_RESET;
			primed   <= 1'b0;
		end else begin
			lastPins <= upperPortBPins;
			primed   <= 1'b1;
		end
	end

	// any differing bit is a change; suppressed until primed
	assign changeEvent = primed && (lastPins != upperPortBPins);
endmodule
`default_nettype wire

/* sim/irq_ctrl_sva.sv */
// checker: bus handshake and request timing of the interrupt block
`default_nettype none
module irq_ctrl_sva
	import irq_ctrl_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        irqRequest
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// both write halves taken on one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// a control write that turns the global enable off
	sequence s_global_off;
		s_wr_taken ##0 s_axi_awaddr == 32'(CTRL_ADDR) && s_axi_wstrb[0]
			&& !s_axi_wdata[GLOBAL_BIT];
	endsequence
	a_write_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_write_refuse: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read not refused");
	a_global_gate: assert property (s_global_off |-> ##3 !irqRequest)
		else $error("request with global enable off");
	a_reset_idle: assert property ($fell(srst) |-> s_axi_awready && s_axi_wready
		&& s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !irqRequest)
		else $error("not idle after reset");
endmodule
`default_nettype wire

/* sim/periph_model.sv */
// partner: peripherals holding request levels and core event pulses
`default_nettype none
module periph_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] wantReq,
	input  wire logic       wantT0,
	input  wire logic       wantExt,
	output var logic  [7:0] peripheralRequest = 8'h00,
	output var logic        timer0Overflow = 1'b0,
	output var logic        externalInterruptPin = 1'b0
);
	logic lastT0 = 1'b0;  // previous command, for edge detection
	logic lastExt = 1'b0;
	// requests are levels; core events are one-cycle pulses on a rise
	always_ff @(posedge core_clk) begin
		peripheralRequest <= wantReq;
		timer0Overflow <= wantT0 && !lastT0;
		externalInterruptPin <= wantExt && !lastExt;
		lastT0 <= wantT0;
		lastExt <= wantExt;
	end
endmodule
`default_nettype wire

/* sim/interrupt_enable_flag_logic_test.sv */
// testbench: register access, flag setting and request gating
`default_nettype none
module interrupt_enable_flag_logic_test
	import irq_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, srst = 1'b1, irqRequest;
	logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready = 1'b0, wantT0 = 1'b0, wantExt = 1'b0, group;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf, upperPortBPins = 4'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  peripheralRequest, wantReq = 8'h00, pie;
	logic        timer0Overflow, externalInterruptPin;
	logic [33:0] expQ[$];  // expected {resp, data} of reads in flight
	logic [1:0]  expB[$];  // expected responses of writes in flight
	int mismatches = 0;
	int compares = 0;
	int seed = 57553;
	always #2 core_clk = ~core_clk;
	interrupt_enable_flag_logic i_interrupt_enable_flag_logic (.core_clk,
		.srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.timer0Overflow, .externalInterruptPin, .upperPortBPins,
		.peripheralRequest, .irqRequest);
	periph_model i_periph_model (.core_clk, .wantReq, .wantT0, .wantExt,
		.peripheralRequest, .timer0Overflow, .externalInterruptPin);
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_write(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t bresp %b expected %b", $time, got, exp);
		end
	endtask
	// request is registered, so let two edges pass before looking
	task automatic cmp_irq(input logic exp);
		repeat (2) @(posedge core_clk);
		compares++;
		if (irqRequest !== exp) begin
			mismatches++;
			$display("[FAIL] %0t request %b expected %b", $time, irqRequest, exp);
		end
	endtask
	// write master: bready offered with the request, held until bvalid
	task automatic wr(input logic [9:0] a, input logic [7:0] d,
		input logic [1:0] r = RESP_OKAY);
		expB.push_back(r);
		@(posedge core_clk);
		s_axi_awaddr <= 32'(a);
		s_axi_wdata <= 32'(d);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
	endtask
	// read master: notes the expectation, the monitor compares
	task automatic rd(input logic [9:0] a, input logic [7:0] d,
		input logic [1:0] r);
		expQ.push_back({r, 24'h0, d});
		@(posedge core_clk);
		s_axi_araddr <= 32'(a);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
	endtask
	// monitor: oldest expectation against each accepted read or response
	always @(posedge core_clk) begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_read({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp_write(s_axi_bresp, expB.pop_front());
	end
	// watchdog: the whole sequence needs well under this
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		rd(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
		rd(PIE_ADDR, PIE_RESET, RESP_OKAY);
		rd(10'h100, 8'h00, RESP_SLVERR);
		wr(CTRL_ADDR, 8'h38);
		rd(CTRL_ADDR, 8'h38, RESP_OKAY);
		// unmapped write and a write with byte lane 0 off change nothing
		wr(10'h100, 8'hff, RESP_SLVERR);
		s_axi_wstrb <= 4'he;
		wr(CTRL_ADDR, 8'hc0);
		s_axi_wstrb <= 4'hf;
		rd(CTRL_ADDR, 8'h38, RESP_OKAY);
		$display("test registers done");
		wr(CTRL_ADDR, 8'h00);
		wantT0 <= 1'b1;
		@(posedge core_clk);
		wantT0 <= 1'b0;
		rd(CTRL_ADDR, 8'h04, RESP_OKAY);
		wantExt <= 1'b1;
		@(posedge core_clk);
		wantExt <= 1'b0;
		rd(CTRL_ADDR, 8'h06, RESP_OKAY);
		upperPortBPins <= 4'ha;
		rd(CTRL_ADDR, 8'h07, RESP_OKAY);
		cmp_irq(1'b0);
		wr(CTRL_ADDR, 8'ha7);
		cmp_irq(1'b1);
		wr(CTRL_ADDR, 8'h27);
		cmp_irq(1'b0);
		wr(CTRL_ADDR, 8'ha3);
		rd(CTRL_ADDR, 8'ha3, RESP_OKAY);
		cmp_irq(1'b0);
		// clear commits in the very cycle the timer0 pulse arrives
		fork
			wr(CTRL_ADDR, 8'h00);
			begin
				@(posedge core_clk);
				wantT0 <= 1'b1;
				@(posedge core_clk);
				wantT0 <= 1'b0;
			end
		join
		rd(CTRL_ADDR, 8'h04, RESP_OKAY);
		$display("test core flags done");
		wr(CTRL_ADDR, 8'h00);
		repeat (10) begin
			pie = 8'($random(seed)) & 8'hbf;
			group = 1'($random(seed));
			wantReq <= 8'($random(seed));
			wr(PIE_ADDR, pie);
			wr(CTRL_ADDR, {1'b1, group, 6'h00});
			rd(PIE_ADDR, pie, RESP_OKAY);
			rd(PFLAG_ADDR, wantReq, RESP_OKAY);
			cmp_irq(group && |(wantReq & pie & 8'hbf));
			cmp_irq(group && |(wantReq & pie & 8'hbf));
		end
		$display("test peripheral gating done");
		print_verdict();
	end
endmodule
bind interrupt_enable_flag_logic irq_ctrl_sva i_irq_ctrl_sva (.core_clk,
	.srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
	.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .irqRequest);
`default_nettype wire
